// ### core/sbr_pkg.sv
// constants shared by the serial baud rate generator files
// assumes a single 10 MHz core clock and an AXI4-Lite register bus
package sbr_pkg;

    // register byte offsets
    localparam logic [3:0] SBR_TX_CTRL_OFS = 4'h0;
    localparam logic [3:0] SBR_RX_CTRL_OFS = 4'h4;
    localparam logic [3:0] SBR_DIVISOR_OFS = 4'h8;
    localparam logic [3:0] SBR_STATUS_OFS = 4'hC;

    // transmit_status_control field positions
    localparam int SBR_CLK_SRC_BIT = 7;
    localparam int SBR_SYNC_BIT = 4;
    localparam int SBR_HIGH_SPEED_BIT = 2;
    localparam int SBR_TX_IDLE_BIT = 1;

    // receive_status_control: port enable at bit 7
    localparam int SBR_PORT_EN_BIT = 7;

    // writable masks and reset values
    localparam logic [7:0] SBR_TX_CTRL_WMASK = 8'hF5;
    localparam logic [7:0] SBR_RX_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] SBR_TX_CTRL_RST = 8'h02;
    localparam logic [7:0] SBR_RX_CTRL_RST = 8'h00;
    localparam logic [7:0] SBR_DIVISOR_RST = 8'h00;

    // core clocks per timer step, minus one; SBR_SAMPLE_COUNT is samples per bit
    localparam logic [5:0] SBR_PRE_ASYNC_LO = 6'd63;
    localparam logic [5:0] SBR_PRE_ASYNC_HI = 6'd15;
    localparam logic [5:0] SBR_PRE_SYNC = 6'd3;
    localparam logic [5:0] SBR_SAMPLE_COUNT = 6'd3;

    // AXI responses
    localparam logic [1:0] SBR_RESP_OKAY = 2'b00;
    localparam logic [1:0] SBR_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SBR_IDLE = 2'b00,
        SBR_RESP = 2'b01
    } sbr_bus_state_t;

    // core clocks per timer step minus one for the selected mode
    function automatic logic [5:0] sbr_prescale(input logic sync, input logic high_speed);
        if (sync) begin
            return SBR_PRE_SYNC;
        end
        return high_speed ? SBR_PRE_ASYNC_HI : SBR_PRE_ASYNC_LO;
    endfunction

endpackage

// ### core/sbr_rate_if.sv
// bundle between the register block, the rate timer and the pin sampler
// assumes one clock domain shared by all three
`timescale 1ns/100ps
interface sbr_rate_if;
    logic [7:0] divisor;
    logic sync;
    logic high_speed;
    logic run;
    logic restart;
    logic bit_tick;
    logic sample_stb;

    modport timer (
        input divisor, sync, high_speed, run, restart,
        output bit_tick, sample_stb
    );
    modport sampler (
        input bit_tick, sample_stb
    );
    modport ctrl (
        output divisor, sync, high_speed, run, restart,
        input bit_tick, sample_stb
    );
endinterface

// ### core/sbr_rate_timer.sv
// free-running 8-bit rate timer with mode prescaler
// assumes restart is a one-cycle pulse from the divisor write
`timescale 1ns/100ps
module sbr_rate_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // control and ticks
    sbr_rate_if.timer rif
);
    import sbr_pkg::*;

    logic [5:0] pre_r;
    logic [5:0] pre_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [5:0] pre_top;
    logic step;
    logic expire;
    logic [7:0] mid;

    assign pre_top = sbr_prescale(rif.sync, rif.high_speed);
    assign step = rif.run && (pre_r >= pre_top);
    assign expire = step && (cnt_r == 8'h00);
    assign mid = rif.divisor >> 1;
    assign pre_nxt = (rif.restart || !rif.run || step) ? 6'h00 : pre_r + 6'd1;
    // count down from divisor, so one period is (divisor+1) steps
    assign cnt_nxt = (rif.restart || !rif.run || expire) ? rif.divisor :
                     (step ? cnt_r - 8'd1 : cnt_r);

    // three samples on consecutive clocks of the middle step
    assign rif.sample_stb = rif.run && !rif.restart && (cnt_r == mid)
                            && (pre_r < SBR_SAMPLE_COUNT);
    assign rif.bit_tick = expire && !rif.restart;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_r <= 6'h00;
            cnt_r <= SBR_DIVISOR_RST;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### core/sbr_majority_vote.sv
// three-sample majority detector for the receive data pin
// assumes the pin is already synchronous to clk_i
`timescale 1ns/100ps
module sbr_majority_vote (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // strobes
    sbr_rate_if.sampler rif,
    // pin and result
    input wire logic rx_pin_i,
    output logic level_o,
    output logic valid_o
);
    import sbr_pkg::*;

    logic [2:0] smp_r;
    logic level_r;
    logic valid_r;
    logic vote;

    assign vote = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smp_r <= 3'b111;
            level_r <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            if (rif.sample_stb) begin
                smp_r <= {smp_r[1:0], rx_pin_i};
            end
            if (rif.bit_tick) begin
                level_r <= vote;
            end
            valid_r <= rif.bit_tick;
        end
    end

    assign level_o = level_r;
    assign valid_o = valid_r;
endmodule

// ### core/sbr_top.sv
// serial baud rate generator: registers, rate timer and receive voter
// assumes an AXI4-Lite master with at most one write and one read in flight
//
// Function
// - one dedicated 8-bit generator serves asynchronous and synchronous modes
// - divisor sets period of free-running 8-bit timer, values 0 to 255
// - in asynchronous mode the high-speed select bit also chooses rate
// - in synchronous mode the high-speed select bit is ignored
// - async low speed: rate is clock over 64 times divisor plus one
// - async high speed: rate is clock over 16 times divisor plus one
// - synchronous: rate is clock over 4 times divisor plus one
// - formulas hold unless synchronous mode selects the external clock, which stops the generator
// - any divisor write with byte lane 0 strobed clears the timer at once
// - receive pin sampled three times per bit, majority vote decides
`timescale 1ns/100ps
module sbr_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [3:0] s_axi_awaddr_i,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [3:0] s_axi_araddr_i,
    // AXI4-Lite read data
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // serial side
    input wire logic receive_data_pin_i,
    output logic bit_tick_o,
    output logic rx_bit_o,
    output logic rx_bit_valid_o
);
    import sbr_pkg::*;

    sbr_rate_if rif ();

    // register state
    logic [7:0] tx_ctrl_r;
    logic [7:0] tx_ctrl_nxt;
    logic [7:0] rx_ctrl_r;
    logic [7:0] rx_ctrl_nxt;
    logic [7:0] divisor_r;
    logic [7:0] divisor_nxt;
    logic bit_seen_r;
    logic bit_seen_nxt;

    // bus state
    sbr_bus_state_t wr_state_r;
    sbr_bus_state_t wr_state_nxt;
    sbr_bus_state_t rd_state_r;
    sbr_bus_state_t rd_state_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // decode
    logic wr_take;
    logic rd_take;
    logic wr_lane0;
    logic wr_tx;
    logic wr_rx;
    logic wr_div;
    logic wr_hit;
    logic rd_hit;
    logic rd_status;
    logic [7:0] rd_byte;
    logic [7:0] status_val;
    logic clk_internal;
    logic rx_level;
    logic rx_valid;

    // write channel: address and data are taken together in one edge
    assign wr_take = (wr_state_r == SBR_IDLE) && s_axi_awvalid_i && s_axi_wvalid_i;
    assign s_axi_awready_o = wr_take;
    assign s_axi_wready_o = wr_take;
    assign wr_lane0 = s_axi_wstrb_i[0];
    assign wr_hit = (s_axi_awaddr_i == SBR_TX_CTRL_OFS) || (s_axi_awaddr_i == SBR_RX_CTRL_OFS)
                    || (s_axi_awaddr_i == SBR_DIVISOR_OFS) || (s_axi_awaddr_i == SBR_STATUS_OFS);
    assign wr_tx = wr_take && wr_lane0 && (s_axi_awaddr_i == SBR_TX_CTRL_OFS);
    assign wr_rx = wr_take && wr_lane0 && (s_axi_awaddr_i == SBR_RX_CTRL_OFS);
    assign wr_div = wr_take && wr_lane0 && (s_axi_awaddr_i == SBR_DIVISOR_OFS);

    // read channel
    assign rd_take = (rd_state_r == SBR_IDLE) && s_axi_arvalid_i;
    assign s_axi_arready_o = rd_state_r == SBR_IDLE;
    assign rd_hit = (s_axi_araddr_i == SBR_TX_CTRL_OFS) || (s_axi_araddr_i == SBR_RX_CTRL_OFS)
                    || (s_axi_araddr_i == SBR_DIVISOR_OFS) || (s_axi_araddr_i == SBR_STATUS_OFS);
    assign rd_status = rd_take && (s_axi_araddr_i == SBR_STATUS_OFS);

    // status: bit0 voted level, bit1 bit seen since last read, bit2 generator running
    assign status_val = {5'b0_0000, clk_internal, bit_seen_r, rx_level};

    assign rd_byte = (s_axi_araddr_i == SBR_TX_CTRL_OFS) ? tx_ctrl_r :
                     (s_axi_araddr_i == SBR_RX_CTRL_OFS) ? rx_ctrl_r :
                     (s_axi_araddr_i == SBR_DIVISOR_OFS) ? divisor_r :
                     (s_axi_araddr_i == SBR_STATUS_OFS) ? status_val : 8'h00;

    // external clock in synchronous slave mode leaves the rate to the far end
    assign clk_internal = !tx_ctrl_r[SBR_SYNC_BIT] || tx_ctrl_r[SBR_CLK_SRC_BIT];

    // generator controls
    // the timer reloads on the write edge itself, so it must see the value being written
    assign rif.divisor = divisor_nxt;
    assign rif.sync = tx_ctrl_r[SBR_SYNC_BIT];
    assign rif.high_speed = tx_ctrl_r[SBR_HIGH_SPEED_BIT] && !tx_ctrl_r[SBR_SYNC_BIT];
    assign rif.run = clk_internal;
    assign rif.restart = wr_div;

    // register next values; read-only bits keep their reset levels
    assign tx_ctrl_nxt = wr_tx ?
        ((s_axi_wdata_i[7:0] & SBR_TX_CTRL_WMASK) | (SBR_TX_CTRL_RST & ~SBR_TX_CTRL_WMASK)) :
        tx_ctrl_r;
    assign rx_ctrl_nxt = wr_rx ?
        ((s_axi_wdata_i[7:0] & SBR_RX_CTRL_WMASK) | (rx_ctrl_r & ~SBR_RX_CTRL_WMASK)) :
        rx_ctrl_r;
    assign divisor_nxt = wr_div ? s_axi_wdata_i[7:0] : divisor_r;

    // a new bit in the same cycle as the clearing read keeps the flag set
    assign bit_seen_nxt = rx_valid ? 1'b1 : (rd_status ? 1'b0 : bit_seen_r);

    // bus state transitions
    assign wr_state_nxt = wr_take ? SBR_RESP :
                          ((wr_state_r == SBR_RESP) && s_axi_bready_i) ? SBR_IDLE : wr_state_r;
    assign rd_state_nxt = rd_take ? SBR_RESP :
                          ((rd_state_r == SBR_RESP) && s_axi_rready_i) ? SBR_IDLE : rd_state_r;
    assign bresp_nxt = wr_take ? (wr_hit ? SBR_RESP_OKAY : SBR_RESP_SLVERR) : bresp_r;
    assign rresp_nxt = rd_take ? (rd_hit ? SBR_RESP_OKAY : SBR_RESP_SLVERR) : rresp_r;
    assign rdata_nxt = rd_take ? {24'h00_0000, rd_byte} : rdata_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_ctrl_r <= SBR_TX_CTRL_RST;
            rx_ctrl_r <= SBR_RX_CTRL_RST;
            divisor_r <= SBR_DIVISOR_RST;
            bit_seen_r <= 1'b0;
        end else begin
            tx_ctrl_r <= tx_ctrl_nxt;
            rx_ctrl_r <= rx_ctrl_nxt;
            divisor_r <= divisor_nxt;
            bit_seen_r <= bit_seen_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_state_r <= SBR_IDLE;
            rd_state_r <= SBR_IDLE;
            bresp_r <= SBR_RESP_OKAY;
            rresp_r <= SBR_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            wr_state_r <= wr_state_nxt;
            rd_state_r <= rd_state_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign s_axi_bvalid_o = wr_state_r == SBR_RESP;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_rvalid_o = rd_state_r == SBR_RESP;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rdata_o = rdata_r;

    sbr_rate_timer u_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .rif(rif.timer)
    );

    sbr_majority_vote u_vote (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .rif(rif.sampler),
        .rx_pin_i(receive_data_pin_i),
        .level_o(rx_level),
        .valid_o(rx_valid)
    );

    assign bit_tick_o = rif.bit_tick;
    assign rx_bit_o = rx_level;
    assign rx_bit_valid_o = rx_valid;
endmodule

// ### testbench/sbr_props.sv
// checker for the baud rate generator, watching the top ports only
// assumes one clock domain; shadows the mode and divisor from bus writes
`timescale 1ns/100ps
module sbr_props
    import sbr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register writes
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // generator
    input wire logic bit_tick_o,
    input wire logic rx_bit_valid_o
);
    logic [7:0] div_r;
    logic [7:0] tx_r;
    logic dirty_r;
    int cnt_r;
    wire wr_w = s_axi_awvalid_i & s_axi_wvalid_i & s_axi_awready_o & s_axi_wstrb_i[0];
    wire div_wr = wr_w && s_axi_awaddr_i == SBR_DIVISOR_OFS;
    wire tx_wr = wr_w && s_axi_awaddr_i == SBR_TX_CTRL_OFS;
    wire sync_w = tx_r[SBR_SYNC_BIT];
    wire hs_w = tx_r[SBR_HIGH_SPEED_BIT];
    // a span begun before reset release or cut by a mode write is not exact
    wire clean_w = bit_tick_o && !dirty_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_r <= SBR_DIVISOR_RST;
            tx_r <= SBR_TX_CTRL_RST;
            dirty_r <= 1'b1;
            cnt_r <= 0;
        end else begin
            if (div_wr) div_r <= s_axi_wdata_i[7:0];
            if (tx_wr) tx_r <= s_axi_wdata_i[7:0];
            cnt_r <= (div_wr || bit_tick_o) ? 0 : cnt_r + 1;
            dirty_r <= tx_wr || (dirty_r && !div_wr && !bit_tick_o);
        end
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_async_lo_rate: assert property (
        clean_w && !sync_w && !hs_w |-> cnt_r == 64 * (div_r + 1) - 1)
        else $error("async low period wrong");
    a_async_hi_rate: assert property (
        clean_w && !sync_w && hs_w |-> cnt_r == 16 * (div_r + 1) - 1)
        else $error("async high period wrong");
    a_sync_rate: assert property (
        clean_w && sync_w |-> cnt_r == 4 * (div_r + 1) - 1)
        else $error("sync period wrong");
    a_stopped_quiet: assert property (
        sync_w && !tx_r[SBR_CLK_SRC_BIT] |-> !bit_tick_o)
        else $error("tick while clock external");
    a_restart_gap: assert property (div_wr |=> !bit_tick_o [*3])
        else $error("tick too soon after divisor write");
    a_tick_single: assert property (bit_tick_o |=> !bit_tick_o)
        else $error("tick longer than one cycle");
    a_vote_follows: assert property (bit_tick_o |=> rx_bit_valid_o)
        else $error("no voted bit after tick");
    a_vote_cause: assert property (rx_bit_valid_o |-> $past(bit_tick_o))
        else $error("voted bit without tick");
    cover property (div_wr);
    cover property (bit_tick_o && sync_w);
    cover property (rx_bit_valid_o);
endmodule

bind sbr_top sbr_props u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .bit_tick_o(bit_tick_o), .rx_bit_valid_o(rx_bit_valid_o)
);

// ### testbench/sbr_remote_model.sv
// remote sender driving the receive data pin
// assumes bit boundaries follow the generator tick
`timescale 1ns/100ps
module sbr_remote_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // bit timing
    input wire logic bit_tick_i,
    // line and the level the voter must settle on
    output logic pin_o,
    output logic exp_o
);
    logic level_r;
    logic glitch_r;
    logic used_r;
    // one single-cycle glitch per bit can spoil only one of three samples
    assign pin_o = level_r ^ glitch_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_r <= 1'b1;
            glitch_r <= 1'b0;
            used_r <= 1'b0;
            exp_o <= 1'b1;
        end else begin
            glitch_r <= !used_r && !glitch_r && !bit_tick_i && ($urandom_range(7) == 0);
            used_r <= !bit_tick_i && (used_r || glitch_r);
            if (bit_tick_i) begin
                exp_o <= level_r;
                level_r <= 1'($urandom);
            end
        end
    end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the baud rate generator
// assumes the package offsets and a remote sender on the receive pin
`timescale 1ns/100ps
module tb_top;
    import sbr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    // responses are always accepted at once
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, tick, rx_bit, rx_valid, pin, exp_bit;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] rst_tab [3] = '{8'h02, 8'h00, 8'h00};
    int error_cnt = 0;
    int compares = 0;

    always #50 clk = ~clk;

    sbr_top uut (
        .clk_i(clk), .resetn_i(resetn), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .receive_data_pin_i(pin), .bit_tick_o(tick), .rx_bit_o(rx_bit), .rx_bit_valid_o(rx_valid)
    );
    sbr_remote_model remote (
        .clk_i(clk), .resetn_i(resetn), .bit_tick_i(tick), .pin_o(pin), .exp_o(exp_bit)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic hs;
        logic [1:0] r;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        hs = 1'b0;
        for (int n = 0; n < 99 && !hs; n++) begin
            @(negedge clk);
            hs = awready && wready;
            @(posedge clk);
        end
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        hs = 1'b0;
        for (int n = 0; n < 99 && !hs; n++) begin
            @(negedge clk);
            hs = bvalid;
            r = bresp;
            @(posedge clk);
        end
        chk("bresp", {29'h0, 1'b1, er}, {29'h0, hs, r});
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs;
        araddr <= a;
        arvalid <= 1'b1;
        hs = 1'b0;
        for (int n = 0; n < 99 && !hs; n++) begin
            @(negedge clk);
            hs = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        hs = 1'b0;
        for (int n = 0; n < 99 && !hs; n++) begin
            @(negedge clk);
            hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end
    endtask

    function automatic int period(input logic s, input logic h, input logic [7:0] d);
        return (s ? 4 : (h ? 16 : 64)) * (d + 1);
    endfunction

    // span between two consecutive ticks, in clocks
    task automatic measure(input int e);
        int n;
        n = 0;
        do @(negedge clk); while (tick !== 1'b1 && ++n < 20000);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 20000);
        chk("tick_period", e, n);
        @(posedge clk);
    endtask

    always @(negedge clk) begin
        if (resetn && rx_valid === 1'b1) begin
            chk("rx_bit", {31'h0, exp_bit}, {31'h0, rx_bit});
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic s;
        logic h;
        logic [7:0] dv;
        int n;
        void'($urandom(32'h6343_3b6d));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(4'(i * 4), d, r);
            chk("reset_value", {24'h00_0000, rst_tab[i]}, d);
        end
        rd(4'h6, d, r);
        chk("unmapped_resp", 32'h0000_0002, {30'h0, r});
        wr(4'h6, 8'h55, 4'h1, 2'b10);
        wr(SBR_RX_CTRL_OFS, 8'hFF, 4'h1, 2'b00);
        rd(SBR_RX_CTRL_OFS, d, r);
        chk("rx_ctrl", 32'h0000_00F8, d);
        wr(SBR_TX_CTRL_OFS, 8'hFF, 4'h1, 2'b00);
        wr(SBR_TX_CTRL_OFS, 8'h00, 4'h0, 2'b00);
        rd(SBR_TX_CTRL_OFS, d, r);
        chk("tx_ctrl", 32'h0000_00F7, d);
        for (int i = 0; i < 9; i++) begin
            s = 1'($urandom_range(1));
            h = 1'($urandom_range(1));
            dv = 8'($urandom_range(7));
            // slow rate through the fast prescaler, then the other boundaries
            if (i == 0) {s, h, dv} = {2'b01, 8'hFF};
            if (i == 1) {s, h, dv} = {2'b00, 8'h00};
            if (i == 2) {s, h, dv} = {2'b11, 8'hFF};
            wr(SBR_TX_CTRL_OFS, {1'b1, 2'b00, s, 1'b0, h, 2'b00}, 4'h1, 2'b00);
            wr(SBR_DIVISOR_OFS, dv, 4'h1, 2'b00);
            rd(SBR_DIVISOR_OFS, d, r);
            chk("divisor", {24'h00_0000, dv}, d);
            measure(period(s, h, dv));
        end
        wr(SBR_TX_CTRL_OFS, 8'h10, 4'h1, 2'b00);
        n = 0;
        repeat (300) begin
            @(negedge clk);
            n += (tick === 1'b1);
        end
        @(posedge clk);
        chk("stopped_ticks", 0, n);
        rd(SBR_STATUS_OFS, d, r);
        chk("running", 0, {31'h0, d[2]});
        chk("status_level", {31'h0, exp_bit}, {31'h0, d[0]});
        chk("bit_seen", 1, {31'h0, d[1]});
        rd(SBR_STATUS_OFS, d, r);
        chk("bit_seen_clr", 0, {31'h0, d[1]});
        summarize();
    end
endmodule
